// >>> pkg/rxfb_pkg.sv
// constants for the receive-indicator frame builder
//
// Summary of operation
// - explicit output selected and I/O sample arrives: emit frame type 0x92.
// - sender 64-bit address in bytes 4 to 11, most significant first.
// - sample frame carries sender 16-bit network address in bytes 12-13, MSB first.
// - sample frame options: 0x01 acknowledged, 0x02 broadcast; host ignores others.
// - byte 15 holds sample set count, always 1.
// - bytes 16-17 carry the digital sampling enable mask.
// - byte 18 carries the analog sampling enable mask.
// - two digital sample bytes only when mask nonzero; unsampled lines read zero.
// - one two-byte reading per enabled analog input, input 0 to 3, then supply.
// - api output option zero and identification message arrives: emit type 0x95.
// - identification options add 0x40, 0x80, 0xC0 delivery codes; host ignores others.
// - bytes 17-24 carry remote node 64-bit address, MSB first.
// - node identifier string copied from byte 25, ended by a zero byte.
// - device type byte: 0 coordinator, 1 normal node, 2 end device.
// - source event byte; 1 means identification pushbutton.
// - profile and manufacturer identifiers as fixed two-byte constants.
// - four descriptor bytes only when discovery options enable them.
// - signal strength byte only when discovery options enable it.
package rxfb_pkg;
    localparam logic [7:0] DELIM = 8'h7E;
    localparam logic [7:0] TYPE_SAMPLE = 8'h92;
    localparam logic [7:0] TYPE_NODEID = 8'h95;
    localparam logic [7:0] CKSUM_BASE = 8'hFF;
    localparam logic [7:0] SAMPLE_COUNT = 8'h01;
    localparam logic [7:0] OPT_SAMPLE_MASK = 8'h03;
    localparam logic [7:0] OPT_NODEID_MASK = 8'hC3;
    localparam logic [7:0] RSVD_HI = 8'hFF;
    localparam logic [7:0] RSVD_LO = 8'hFE;
    localparam logic [7:0] NUL = 8'h00;
    localparam logic [1:0] DEVTYPE_MAX = 2'h2;
    // profile and maker words: arbitrary values
    localparam logic [15:0] PROFILE_ID = 16'h1234;
    localparam logic [15:0] MAKER_ID = 16'h5678;
    localparam int NI_MAX = 20;
    localparam int NI_IDX_W = 5;
    localparam int ANA_CH = 5;
    localparam int FIFO_DEPTH = 16;
    // register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_SRC_HI = 8'h08;
    localparam logic [7:0] A_SRC_LO = 8'h0C;
    localparam logic [7:0] A_REM_HI = 8'h10;
    localparam logic [7:0] A_REM_LO = 8'h14;
    localparam logic [7:0] A_INFO = 8'h18;
    localparam logic [7:0] A_MASKS = 8'h1C;
    localparam logic [7:0] A_ANA01 = 8'h20;
    localparam logic [7:0] A_ANA23 = 8'h24;
    localparam logic [7:0] A_ANASUP = 8'h28;
    localparam logic [7:0] A_DDV = 8'h2C;
    localparam logic [7:0] A_NI = 8'h30;
    localparam logic [7:0] A_START = 8'h34;
    // control bits
    localparam int C_AO = 0;
    localparam int C_DD_EN = 1;
    localparam int C_RSSI_EN = 2;
    // start register bits
    localparam int S_SAMPLE = 0;
    localparam int S_NODEID = 1;
    typedef enum {ST_IDLE, ST_EMIT, ST_CSUM} rxfb_state_e;
endpackage : rxfb_pkg

// >>> logic/rxfb_top.sv
// frame builder with AHB-Lite register slave and output byte fifo
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns

// ****************
// byte fifo
// ****************
module rxfb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk, // clock
    input wire logic rstN, // synchronous-release reset
    input wire logic inValid, // write strobe
    output logic inReady, // not full
    input wire logic [WIDTH-1:0] inData, // write data
    output logic outValid, // not empty
    input wire logic outReady, // read strobe
    output logic [WIDTH-1:0] outData // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    logic doWr;
    logic doRd;
    assign inReady = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;
    assign outData = mem[rdPtr_r];
    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_r] <= inData;
        end
    end
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (doWr) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (doRd) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(doWr) - (AW+1)'(doRd);
        end
    end
endmodule : rxfb_fifo

// ****************
// top
// ****************
module rxfb_top
    import rxfb_pkg::*;
(
    input wire logic clk_sys, // 25 MHz clock
    input wire logic arst_n, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic [2:0] hsize, // size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic hreadyout, // slave ready
    output logic hresp, // response, always okay
    output logic [31:0] hrdata, // read data
    output logic txValid, // serial byte available
    input wire logic txReady, // serial side takes byte
    output logic [7:0] txData // serial byte
);
    import rxfb_pkg::*;

    // ****************
    // reset and bus
    // ****************
    logic rstMeta_r;
    logic rstN;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_r <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstN <= rstMeta_r;
        end
    end

    logic wrPend_r;
    logic [7:0] wrAddr_r;
    logic [7:0] rdAddr;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign rdAddr = haddr[7:0];
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
        end else begin
            wrPend_r <= hsel && hready && htrans[1] && hwrite;
            wrAddr_r <= haddr[7:0];
        end
    end
    logic wrEn;
    assign wrEn = wrPend_r;

    // ****************
    // frame content registers
    // ****************
    logic [2:0] ctrl_r;
    logic [63:0] srcAddr_r;
    logic [63:0] remAddr_r;
    logic [31:0] info_r; // [15:0] net addr, [23:16] options, [25:24] dev type, [31:26] event
    logic [31:0] masks_r; // [15:0] digital mask, [23:16] analog mask
    logic [15:0] digSamp_r;
    logic [15:0] ana_r [ANA_CH];
    logic [31:0] ddv_r;
    logic [7:0] rssi_r;
    logic [7:0] ni_r [NI_MAX];
    logic [NI_IDX_W-1:0] niLen_r;
    logic busy_r;
    logic [7:0] frameCnt_r;
    logic [1:0] kind_r;
    logic startSample;
    logic startNode;
    assign startSample = wrEn && wrAddr_r == A_START && hwdata[S_SAMPLE] && !busy_r
                         && ctrl_r[C_AO];
    assign startNode = wrEn && wrAddr_r == A_START && hwdata[S_NODEID] && !busy_r
                       && !ctrl_r[C_AO];

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            ctrl_r <= 3'h0;
            srcAddr_r <= 64'h0;
            remAddr_r <= 64'h0;
            info_r <= 32'h0;
            masks_r <= 32'h0;
            digSamp_r <= 16'h0;
            ddv_r <= 32'h0;
            rssi_r <= 8'h00;
            for (int i = 0; i < ANA_CH; i++) begin
                ana_r[i] <= 16'h0;
            end
        end else if (wrEn && !busy_r) begin
            case (wrAddr_r)
                A_CTRL: ctrl_r <= hwdata[2:0];
                A_SRC_HI: srcAddr_r[63:32] <= hwdata;
                A_SRC_LO: srcAddr_r[31:0] <= hwdata;
                A_REM_HI: remAddr_r[63:32] <= hwdata;
                A_REM_LO: remAddr_r[31:0] <= hwdata;
                A_INFO: info_r <= hwdata;
                A_MASKS: masks_r <= hwdata;
                A_ANA01: begin
                    ana_r[0] <= hwdata[15:0];
                    ana_r[1] <= hwdata[31:16];
                end
                A_ANA23: begin
                    ana_r[2] <= hwdata[15:0];
                    ana_r[3] <= hwdata[31:16];
                end
                A_ANASUP: begin
                    ana_r[4] <= hwdata[15:0];
                    digSamp_r <= hwdata[31:16];
                end
                A_DDV: ddv_r <= hwdata;
                A_STAT: rssi_r <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    // name string written one byte per access; a zero byte clears it
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            niLen_r <= '0;
        end else if (wrEn && !busy_r && wrAddr_r == A_NI) begin
            if (hwdata[7:0] == NUL) begin
                niLen_r <= '0;
            end else if (niLen_r != NI_IDX_W'(NI_MAX)) begin
                niLen_r <= niLen_r + 1'b1;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (wrEn && !busy_r && wrAddr_r == A_NI && niLen_r != NI_IDX_W'(NI_MAX)) begin
            ni_r[niLen_r] <= hwdata[7:0];
        end
    end

    // ****************
    // frame byte sequencer
    // ****************
    rxfb_state_e state_r;
    logic [7:0] idx_r;
    logic [7:0] sum_r;
    logic [15:0] dataLen;
    logic [7:0] curByte;
    logic fifoReady;
    logic push;

    // number of set bits in the analog mask that reach the readings
    function automatic logic [3:0] anaCount(input logic [7:0] m);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < ANA_CH; i++) begin
            c = c + 4'(m[i == ANA_CH-1 ? 7 : i]);
        end
        return c;
    endfunction : anaCount

    // bit of the analog mask for reading slot s: inputs 0..3, supply is bit 7
    function automatic logic anaBit(input logic [7:0] m, input int s);
        return m[s == ANA_CH-1 ? 7 : s];
    endfunction : anaBit

    always_comb begin
        dataLen = 16'h0;
        if (kind_r[0]) begin
            dataLen = 16'd16 + ((masks_r[15:0] != 16'h0) ? 16'd2 : 16'd0)
                      + {11'h0, anaCount(masks_r[23:16]), 1'b0};
        end else begin
            dataLen = 16'd31 + {11'h0, niLen_r}
                      + (ctrl_r[C_DD_EN] ? 16'd4 : 16'd0)
                      + (ctrl_r[C_RSSI_EN] ? 16'd1 : 16'd0);
        end
    end

    // nth analog reading present in the frame, in channel order
    function automatic logic [15:0] anaPick(input logic [7:0] m, input logic [3:0] n,
                                            input logic [79:0] v);
        logic [3:0] k;
        logic [15:0] r;
        k = 4'h0;
        r = 16'h0;
        for (int s = 0; s < ANA_CH; s++) begin
            if (anaBit(m, s)) begin
                if (k == n) begin
                    r = v[s*16 +: 16];
                end
                k = k + 4'h1;
            end
        end
        return r;
    endfunction : anaPick

    logic [79:0] anaFlat;
    genvar g;
    generate
        for (g = 0; g < ANA_CH; g++) begin : g_ana
            assign anaFlat[g*16 +: 16] = ana_r[g];
        end
    endgenerate

    logic [7:0] b; // byte index counted from the delimiter, same as idx_r
    logic [15:0] digMasked;
    logic [15:0] anaVal;
    logic [7:0] anaBase;
    logic [7:0] niEnd;
    logic [7:0] rel;
    assign digMasked = digSamp_r & masks_r[15:0];
    assign anaBase = (masks_r[15:0] != 16'h0) ? 8'd21 : 8'd19;
    assign niEnd = 8'd25 + {3'h0, niLen_r};
    always_comb begin
        b = idx_r;
        rel = 8'h0;
        anaVal = 16'h0;
        curByte = NUL;
        if (idx_r == 8'd0) begin
            curByte = DELIM;
        end else if (idx_r == 8'd1) begin
            curByte = dataLen[15:8];
        end else if (idx_r == 8'd2) begin
            curByte = dataLen[7:0];
        end else if (idx_r == 8'd3) begin
            curByte = kind_r[0] ? TYPE_SAMPLE : TYPE_NODEID;
        end else if (b <= 8'd11) begin
            curByte = srcAddr_r[8*(11-b) +: 8];
        end else if (kind_r[0]) begin
            if (b == 8'd12) begin
                curByte = info_r[15:8];
            end else if (b == 8'd13) begin
                curByte = info_r[7:0];
            end else if (b == 8'd14) begin
                curByte = info_r[23:16] & OPT_SAMPLE_MASK;
            end else if (b == 8'd15) begin
                curByte = SAMPLE_COUNT;
            end else if (b == 8'd16) begin
                curByte = masks_r[15:8];
            end else if (b == 8'd17) begin
                curByte = masks_r[7:0];
            end else if (b == 8'd18) begin
                curByte = masks_r[23:16];
            end else if (b < anaBase) begin
                curByte = (b == 8'd19) ? digMasked[15:8] : digMasked[7:0];
            end else begin
                rel = b - anaBase;
                anaVal = anaPick(masks_r[23:16], rel[4:1], anaFlat);
                curByte = rel[0] ? anaVal[7:0] : anaVal[15:8];
            end
        end else begin
            if (b == 8'd12 || b == 8'd15) begin
                curByte = RSVD_HI;
            end else if (b == 8'd13 || b == 8'd16) begin
                curByte = RSVD_LO;
            end else if (b == 8'd14) begin
                curByte = info_r[23:16] & OPT_NODEID_MASK;
            end else if (b <= 8'd24) begin
                curByte = remAddr_r[8*(24-b) +: 8];
            end else if (b < niEnd) begin
                rel = b - 8'd25;
                curByte = ni_r[rel[NI_IDX_W-1:0]];
            end else if (b == niEnd) begin
                curByte = NUL;
            end else begin
                rel = b - niEnd;
                case (rel)
                    8'd1: curByte = RSVD_HI;
                    8'd2: curByte = RSVD_LO;
                    8'd3: curByte = {6'h0, (info_r[25:24] > DEVTYPE_MAX) ? DEVTYPE_MAX
                                                                   : info_r[25:24]};
                    8'd4: curByte = {2'h0, info_r[31:26]};
                    8'd5: curByte = PROFILE_ID[15:8];
                    8'd6: curByte = PROFILE_ID[7:0];
                    8'd7: curByte = MAKER_ID[15:8];
                    8'd8: curByte = MAKER_ID[7:0];
                    default: begin
                        if (ctrl_r[C_DD_EN] && rel <= 8'd12) begin
                            curByte = ddv_r[8*(12-rel) +: 8];
                        end else begin
                            curByte = rssi_r;
                        end
                    end
                endcase
            end
        end
    end

    assign push = (state_r != ST_IDLE) && fifoReady;
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            state_r <= ST_IDLE;
            idx_r <= 8'h0;
            sum_r <= 8'h0;
            kind_r <= 2'h0;
            busy_r <= 1'b0;
            frameCnt_r <= 8'h0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (startSample || startNode) begin
                        kind_r <= {startNode, startSample};
                        idx_r <= 8'h0;
                        sum_r <= 8'h0;
                        busy_r <= 1'b1;
                        state_r <= ST_EMIT;
                    end
                end
                ST_EMIT: begin
                    if (fifoReady) begin
                        if (idx_r >= 8'd3) begin
                            sum_r <= sum_r + curByte;
                        end
                        idx_r <= idx_r + 8'd1;
                        if (idx_r >= 8'd3 && idx_r == dataLen[7:0] + 8'd2) begin
                            state_r <= ST_CSUM;
                        end
                    end
                end
                ST_CSUM: begin
                    if (fifoReady) begin
                        busy_r <= 1'b0;
                        frameCnt_r <= frameCnt_r + 8'd1;
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    logic [7:0] fifoIn;
    assign fifoIn = (state_r == ST_CSUM) ? CKSUM_BASE - sum_r : curByte;
    rxfb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk_sys),
        .rstN(rstN),
        .inValid(push),
        .inReady(fifoReady),
        .inData(fifoIn),
        .outValid(txValid),
        .outReady(txReady),
        .outData(txData)
    );

    // ****************
    // read data
    // ****************
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            hrdata <= 32'h0;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            case (rdAddr)
                A_CTRL: hrdata <= {29'h0, ctrl_r};
                A_STAT: hrdata <= {8'h0, frameCnt_r, rssi_r, 7'h0, busy_r};
                A_SRC_HI: hrdata <= srcAddr_r[63:32];
                A_SRC_LO: hrdata <= srcAddr_r[31:0];
                A_REM_HI: hrdata <= remAddr_r[63:32];
                A_REM_LO: hrdata <= remAddr_r[31:0];
                A_INFO: hrdata <= info_r;
                A_MASKS: hrdata <= masks_r;
                A_DDV: hrdata <= ddv_r;
                A_NI: hrdata <= {27'h0, niLen_r};
                default: hrdata <= 32'h0;
            endcase
        end
    end
endmodule : rxfb_top

// >>> sim/rxfb_top_asserts.sv
// port assertions for the frame builder
`timescale 1ns/1ns
module rxfb_top_asserts (
    input wire logic clk_sys, // clock
    input wire logic arst_n, // async reset, active low
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic txValid, // byte available
    input wire logic txReady, // byte taken
    input wire logic [7:0] txData // serial byte
);
    logic take;
    logic last;
    logic [7:0] idx_r;
    logic [15:0] len_r;
    logic [7:0] sum_r;
    logic [7:0] typ_r;
    assign take = txValid && txReady;
    assign last = (idx_r > 8'h03) && ({8'h00, idx_r} == len_r + 16'h0003);
    // ****************
    // frame position tracking
    // ****************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            idx_r <= 8'h00;
        end else if (take) begin
            idx_r <= last ? 8'h00 : idx_r + 8'h01;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            len_r <= 16'h0000;
            typ_r <= 8'h00;
        end else if (take) begin
            if (idx_r == 8'h01) len_r[15:8] <= txData;
            if (idx_r == 8'h02) len_r[7:0] <= txData;
            if (idx_r == 8'h03) typ_r <= txData;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sum_r <= 8'h00;
        end else if (take) begin
            sum_r <= (idx_r < 8'h03) ? 8'h00 : sum_r + txData;
        end
    end
    // ****************
    // assertions
    // ****************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    a_delim_first: assert property (take && idx_r == 8'h00 |-> txData == 8'h7E)
        else $error("frame does not open with the delimiter");
    a_type_known: assert property (take && idx_r == 8'h03 |-> txData inside {8'h92, 8'h95})
        else $error("unknown frame type");
    a_sum_closes: assert property (take && last |-> txData == 8'hFF - sum_r)
        else $error("bad checksum byte");
    a_count_one: assert property (take && idx_r == 8'h0F && typ_r == 8'h92 |-> txData == 8'h01)
        else $error("sample count not one");
    a_opts_sample: assert property (take && idx_r == 8'h0E && typ_r == 8'h92 |-> (txData & 8'hFC) == 8'h00)
        else $error("sample options carry stray bits");
    a_opts_node: assert property (take && idx_r == 8'h0E && typ_r == 8'h95 |-> (txData & 8'h3C) == 8'h00)
        else $error("node options carry stray bits");
    a_byte_holds: assert property (txValid && !txReady |=> txValid && $stable(txData))
        else $error("byte dropped while stalled");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    c_sample: cover property (take && idx_r == 8'h03 && txData == 8'h92);
    c_node: cover property (take && idx_r == 8'h03 && txData == 8'h95);
    c_stall: cover property (txValid && !txReady [*8]);
endmodule : rxfb_top_asserts
bind rxfb_top rxfb_top_asserts u_chk (.clk_sys(clk_sys), .arst_n(arst_n), .hreadyout(hreadyout),
    .hresp(hresp), .txValid(txValid), .txReady(txReady), .txData(txData));

// >>> sim/rxfb_host_model.sv
// host reading the serial byte stream with random stalls
`timescale 1ns/1ns
module rxfb_host_model (
    input wire logic clk_sys, // clock
    input wire logic txValid, // byte available
    input wire logic [7:0] txData, // serial byte
    input wire logic hold, // stall completely
    output logic txReady // host takes byte
);
    int seed = 83004;
    logic [7:0] got[$];
    initial txReady = 1'b0;
    always @(posedge clk_sys) begin
        if (txValid && txReady) begin
            got.push_back(txData);
        end
        txReady <= !hold && (($random(seed) & 3) != 0);
    end
endmodule : rxfb_host_model

// >>> sim/rxfb_top_tb.sv
// self-checking testbench for the frame builder
`timescale 1ns/1ns
module rxfb_top_tb;
    import rxfb_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hold = 1'b1;
    logic hreadyout, hresp, txValid, txReady;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [7:0] txData;
    logic [7:0] expQ[$];
    int seed = 83004;
    int errTotal = 0;
    int checked = 0;
    int frames = 0;
    always #20 clk_sys = ~clk_sys;
    rxfb_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .txValid(txValid),
        .txReady(txReady), .txData(txData));
    rxfb_host_model host (.clk_sys(clk_sys), .txValid(txValid), .txData(txData), .hold(hold),
        .txReady(txReady));
    // ****************
    // shared tasks
    // ****************
    task automatic giveVerdict();
        $display("comparisons %0d mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : giveVerdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            errTotal++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic waitReady();
        int n;
        n = 0;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                errTotal++;
                giveVerdict();
            end
            @(posedge clk_sys);
        end
    endtask : waitReady
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        waitReady();
        htrans <= 2'h0;
        hwdata <= wd;
        waitReady();
        rd = hrdata;
    endtask : bus
    function automatic void put(input logic [63:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
            expQ.push_back(v[8*i +: 8]);
    endfunction : put
    function automatic void seal();
        logic [7:0] s;
        logic [15:0] l;
        s = 8'h00;
        l = 16'(expQ.size());
        foreach (expQ[i])
            s += expQ[i];
        expQ.push_back(CKSUM_BASE - s);
        expQ.push_front(l[7:0]);
        expQ.push_front(l[15:8]);
        expQ.push_front(DELIM);
    endfunction : seal
    task automatic frameCheck();
        int n;
        n = 0;
        while (host.got.size() < expQ.size()) begin
            n++;
            if (n > 3000) begin
                errTotal++;
                giveVerdict();
            end
            @(posedge clk_sys);
        end
        repeat (4) @(posedge clk_sys);
        chk(32'(host.got.size()), 32'(expQ.size()));
        foreach (expQ[i])
            chk(host.got[i], expQ[i]);
        host.got.delete();
        frames++;
    endtask : frameCheck
    // ****************
    // main sequence
    // ****************
    initial begin
        logic [63:0] src, rem, ana;
        logic [31:0] info, sup, ddv;
        logic [15:0] dm;
        logic [7:0] am, rssi;
        int nl;
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        hold <= 1'b0;
        repeat (3) @(posedge clk_sys);
        bus(1'b0, A_STAT, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, A_CTRL, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 8'h3C, 32'h0);
        chk(rd, 32'h0);
        $display("reset test done");
        bus(1'b1, A_CTRL, 32'h1);
        for (int i = 0; i < 8; i++) begin
            src = {$random(seed), $random(seed)};
            ana = {$random(seed), $random(seed)};
            info = $random(seed);
            sup = $random(seed);
            dm = (i == 0) ? 16'h0 : (i == 1) ? 16'hFFFF : 16'($random(seed));
            am = (i == 0) ? 8'h0 : (i == 1) ? 8'h8F : 8'($random(seed)) & 8'h8F;
            bus(1'b1, A_SRC_HI, src[63:32]);
            bus(1'b1, A_SRC_LO, src[31:0]);
            bus(1'b1, A_INFO, info);
            bus(1'b1, A_MASKS, {8'h0, am, dm});
            bus(1'b1, A_ANA01, ana[31:0]);
            bus(1'b1, A_ANA23, ana[63:32]);
            bus(1'b1, A_ANASUP, sup);
            expQ = {TYPE_SAMPLE};
            put(src, 8);
            put(info, 2);
            expQ.push_back(info[23:16] & OPT_SAMPLE_MASK);
            expQ.push_back(SAMPLE_COUNT);
            put(dm, 2);
            put(am, 1);
            if (dm != 16'h0)
                put(sup[31:16] & dm, 2);
            for (int k = 0; k < 4; k++)
                if (am[k]) put(ana >> (16 * k), 2);
            if (am[7])
                put(sup, 2);
            seal();
            bus(1'b1, A_START, 32'h1);
            frameCheck();
        end
        $display("sample frame test done");
        bus(1'b1, A_START, 32'h2);
        bus(1'b1, A_CTRL, 32'h0);
        bus(1'b1, A_START, 32'h1);
        repeat (40) @(posedge clk_sys);
        chk(32'(host.got.size()), 32'h0);
        $display("refused start test done");
        for (int i = 0; i < 4; i++) begin
            src = {$random(seed), $random(seed)};
            rem = {$random(seed), $random(seed)};
            info = $random(seed);
            ddv = $random(seed);
            rssi = 8'($random(seed));
            nl = (i == 3) ? NI_MAX : i;
            bus(1'b1, A_CTRL, 32'(i << 1));
            bus(1'b1, A_STAT, {24'h0, rssi});
            bus(1'b1, A_SRC_HI, src[63:32]);
            bus(1'b1, A_SRC_LO, src[31:0]);
            bus(1'b1, A_REM_HI, rem[63:32]);
            bus(1'b1, A_REM_LO, rem[31:0]);
            bus(1'b1, A_INFO, info);
            bus(1'b1, A_DDV, ddv);
            bus(1'b1, A_NI, 32'h0);
            expQ = {TYPE_NODEID};
            put(src, 8);
            put({RSVD_HI, RSVD_LO}, 2);
            expQ.push_back(info[23:16] & OPT_NODEID_MASK);
            put({RSVD_HI, RSVD_LO}, 2);
            put(rem, 8);
            for (int k = 0; k < nl; k++) begin
                bus(1'b1, A_NI, 32'h41 + 32'(k));
                expQ.push_back(8'h41 + 8'(k));
            end
            expQ.push_back(NUL);
            put({RSVD_HI, RSVD_LO}, 2);
            expQ.push_back((info[25:24] > DEVTYPE_MAX) ? 8'h02 : {6'h0, info[25:24]});
            expQ.push_back({2'h0, info[31:26]});
            put({PROFILE_ID, MAKER_ID}, 4);
            if (i[0])
                put(ddv, 4);
            if (i[1])
                expQ.push_back(rssi);
            seal();
            bus(1'b0, A_NI, 32'h0);
            chk(rd, 32'(nl));
            hold <= (i == 3);
            bus(1'b1, A_START, 32'h2);
            if (i == 3) begin
                repeat (60) @(posedge clk_sys);
                chk(txValid, 1'b1);
                chk(32'(host.got.size()), 32'h0);
                hold <= 1'b0;
            end
            frameCheck();
        end
        $display("node frame test done");
        bus(1'b0, A_STAT, 32'h0);
        chk(rd, {8'h0, 8'(frames), rssi, 8'h00});
        $display("status test done");
        giveVerdict();
    end
endmodule : rxfb_top_tb
